// ===== design/cpu_timers.sv
// module: 64-bit time base with interval, fixed-interval and watchdog timers
// ----------------------------------------
// What this block does
// R1: 64-bit time base counts up continuously
// R2: advance from cpu clock or external tick
// R3: time base wrap raises no interrupt
// R4: all timers step with time-base advance
// R5: 32-bit interval count decrements per advance
// R6: software write loads the interval count
// R7: at zero, stop and raise interval interrupt
// R8: auto-reload restores last written value
// R9: fixed-interval timer picks one of four taps
// R10: fixed interrupt only on tap rising edge
// R11: watchdog interrupts each completed interval
// R12: four watchdog periods, selectable reset type
// R13: two unserviced intervals issue configured reset
// R14: first expiry sets status, second resets
// R15: status sticky until cleared; time base readable
// ----------------------------------------
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ns
module cpu_timers
  import cpu_timers_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // external timer clock
  input  wire logic              ext_tick_i,
  // to core exception and reset logic
  output logic                   irq_o,
  output logic                   wd_reset_o,
  output logic      [1:0]        wd_reset_type_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [TB_W-1:0]   tb_reg;
  logic [DATA_W-1:0] tb_hi_snap_reg;
  logic [ITV_W-1:0]  itv_reg;
  logic [ITV_W-1:0]  itv_next;
  logic [ITV_W-1:0]  reload_reg;
  ctrl_s             ctrl_reg;
  irq_s              status_reg;
  irq_s              status_next;
  irq_s              mask_reg;
  irq_s              set_bits;
  irq_s              clr_bits;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] read_next;
  logic              irq_reg;
  logic              wd_reset_reg;
  logic [1:0]        wd_type_reg;
  logic              advance;
  logic              fit_rise;
  logic              wd_expire;
  logic              wd_fire;
  logic              itv_hit;
  logic              wr_itv;
  logic              wr_status;
  logic [TAP_N-1:0]  fit_taps;
  logic [TAP_N-1:0]  wd_taps;

  assign wr_itv    = wr_i && (addr_i == OFS_ITV);
  assign wr_status = wr_i && (addr_i == OFS_STATUS);

  // ----------------------------------------
  // advance source
  // ----------------------------------------
  tick_source u_tick (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .ext_src_i  (ctrl_reg.ext_src),
    .ext_tick_i (ext_tick_i),
    .advance_o  (advance)
  );

  // ----------------------------------------
  // time base
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tb_reg <= TB_RST;
    end else if (advance) begin
      tb_reg <= tb_reg + 64'h1; // R1 R3
    end
  end

  // high word frozen by a low-word read for a tear-free pair
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tb_hi_snap_reg <= RDATA_RST;
    end else if (rd_i && (addr_i == OFS_TB_LO)) begin
      tb_hi_snap_reg <= tb_reg[TB_W-1:DATA_W];
    end
  end

  // ----------------------------------------
  // tap vectors
  // ----------------------------------------
  for (genvar g = 0; g < TAP_N; g++) begin : g_taps
    assign fit_taps[g] = tb_reg[FIT_TAPS[g]]; // R9
    assign wd_taps[g]  = tb_reg[WD_TAPS[g]]; // R12
  end

  tap_rise u_fit (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .taps_i    (fit_taps),
    .sel_i     (ctrl_reg.fit_sel),
    .rise_o    (fit_rise)
  );

  tap_rise u_wd (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .taps_i    (wd_taps),
    .sel_i     (ctrl_reg.wd_sel),
    .rise_o    (wd_expire)
  );

  // ----------------------------------------
  // interval countdown
  // ----------------------------------------
  assign itv_hit = advance && !wr_itv && (itv_reg == 32'h1); // R7

  always_comb begin
    itv_next = itv_reg;
    if (wr_itv) begin
      itv_next = wdata_i; // R6
    end else if (advance && (itv_reg != ITV_RST)) begin
      if (itv_reg == 32'h1 && ctrl_reg.auto_reload) begin
        itv_next = reload_reg; // R8
      end else begin
        itv_next = itv_reg - 32'h1; // R4 R5
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      itv_reg <= ITV_RST;
    end else begin
      itv_reg <= itv_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reload_reg <= ITV_RST;
    end else if (wr_itv) begin
      reload_reg <= wdata_i; // R8
    end
  end

  // ----------------------------------------
  // control and mask
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_i && (addr_i == OFS_CTRL)) begin
      ctrl_reg <= ctrl_s'(wdata_i[CTRL_W-1:0]); // R12
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mask_reg <= IRQ_RST;
    end else if (wr_i && (addr_i == OFS_MASK)) begin
      mask_reg <= irq_s'(wdata_i[IRQ_W-1:0]);
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // a clear in the expiry cycle counts as service
  assign wd_fire = wd_expire && ctrl_reg.wd_en && status_reg.wdog
                   && !(wr_status && wdata_i[IRQ_WD_BIT]); // R13 R14

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wd_reset_reg <= 1'b0;
    end else begin
      wd_reset_reg <= wd_fire; // R13
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wd_type_reg <= 2'h0;
    end else if (wd_fire) begin
      wd_type_reg <= ctrl_reg.wd_type; // R12
    end
  end

  // ----------------------------------------
  // status, sticky with write-one-to-clear
  // ----------------------------------------
  always_comb begin
    set_bits          = IRQ_RST;
    set_bits.interval = itv_hit; // R7
    set_bits.fixed    = fit_rise; // R10
    set_bits.wdog     = wd_expire; // R11 R14
    clr_bits          = wr_status ? irq_s'(wdata_i[IRQ_W-1:0]) : IRQ_RST;
    status_next       = (status_reg & ~clr_bits) | set_bits; // R15
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      status_reg <= IRQ_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & mask_reg); // R15
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb begin
    read_next = RDATA_RST;
    case (addr_i)
      OFS_TB_LO:  read_next = tb_reg[DATA_W-1:0]; // R15
      OFS_TB_HI:  read_next = tb_hi_snap_reg;
      OFS_ITV:    read_next = itv_reg;
      OFS_RELOAD: read_next = reload_reg;
      OFS_CTRL:   read_next = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
      OFS_STATUS: read_next = {{(DATA_W-IRQ_W){1'b0}}, status_reg};
      OFS_MASK:   read_next = {{(DATA_W-IRQ_W){1'b0}}, mask_reg};
      default:    read_next = RDATA_RST;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_reg <= RDATA_RST;
    end else if (rd_i) begin
      rdata_reg <= read_next;
    end else begin
      rdata_reg <= RDATA_RST;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata_o         = rdata_reg;
  assign irq_o           = irq_reg;
  assign wd_reset_o      = wd_reset_reg;
  assign wd_reset_type_o = wd_type_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence wd_first_expiry;
    wd_expire && ctrl_reg.wd_en && !status_reg.wdog;
  endsequence

  sequence wd_unserviced_expiry;
    wd_expire && status_reg.wdog && !wr_status;
  endsequence

  tb_count_up_a: assert property ( // R1
    advance |=> tb_reg == $past(tb_reg) + 64'h1)
    else $error("time base did not count up");

  tb_hold_still_a: assert property ( // R2
    !advance |=> $stable(tb_reg))
    else $error("time base moved without an advance");

  tb_wrap_quiet_a: assert property ( // R3
    (advance && (&tb_reg) && !itv_hit && !fit_rise && !wd_expire)
    |=> tb_reg == TB_RST && status_reg == $past(status_reg))
    else $error("wrap changed time base or status wrongly");

  itv_decrement_a: assert property ( // R5
    (advance && !wr_itv && itv_reg > 32'h1) |=> itv_reg == $past(itv_reg) - 32'h1)
    else $error("interval count did not decrement");

  itv_load_a: assert property ( // R6
    wr_itv |=> itv_reg == $past(wdata_i) && reload_reg == $past(wdata_i))
    else $error("interval write not loaded");

  itv_stop_zero_a: assert property ( // R7
    (itv_reg == ITV_RST && !wr_itv) |=> itv_reg == ITV_RST)
    else $error("interval count left zero on its own");

  itv_hit_irq_a: assert property ( // R7
    (itv_hit && !ctrl_reg.auto_reload) |=> status_reg.interval && itv_reg == ITV_RST)
    else $error("interval expiry missed");

  itv_reload_a: assert property ( // R8
    (itv_hit && ctrl_reg.auto_reload) |=> itv_reg == $past(reload_reg))
    else $error("auto reload failed");

  fit_edge_irq_a: assert property ( // R10
    fit_rise |=> status_reg.fixed)
    else $error("fixed interval event lost");

  fit_no_fall_a: assert property ( // R10
    $fell(fit_taps[ctrl_reg.fit_sel]) && $stable(ctrl_reg) |-> !fit_rise)
    else $error("fixed interval fired on falling tap");

  wd_first_stage_a: assert property ( // R14
    wd_first_expiry |=> status_reg.wdog && !wd_reset_o)
    else $error("watchdog first expiry wrong");

  wd_second_stage_a: assert property ( // R13
    (wd_unserviced_expiry and ctrl_reg.wd_en) |=> wd_reset_o
    && wd_reset_type_o == $past(ctrl_reg.wd_type))
    else $error("watchdog reset not issued");

  wd_disabled_a: assert property ( // R13
    !ctrl_reg.wd_en |=> !wd_reset_o)
    else $error("reset issued while watchdog disabled");

  status_sticky_a: assert property ( // R15
    (status_reg.interval && !(wr_status && wdata_i[IRQ_ITV_BIT]))
    |=> status_reg.interval)
    else $error("interval status dropped without clear");

  irq_level_a: assert property ( // R15
    |(status_reg & mask_reg) |-> ##[0:1] irq_o)
    else $error("interrupt output not raised");

endmodule

// ===== design/cpu_timers_pkg.sv
// package: constants and carriers for the time base and its three timers
package cpu_timers_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TB_W   = 64;
  localparam int ITV_W  = 32;
  localparam int TAP_N  = 4;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_TB_LO  = 8'h00;
  localparam logic [7:0] OFS_TB_HI  = 8'h04;
  localparam logic [7:0] OFS_ITV    = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0c;
  localparam logic [7:0] OFS_CTRL   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_EXT_SRC_BIT = 0;
  localparam int CTRL_RELOAD_BIT  = 1;
  localparam int CTRL_FIT_SEL_LSB = 2;
  localparam int CTRL_WD_SEL_LSB  = 4;
  localparam int CTRL_WD_TYPE_LSB = 6;
  localparam int CTRL_WD_EN_BIT   = 8;
  localparam int CTRL_W           = 9;
  localparam int IRQ_ITV_BIT      = 0;
  localparam int IRQ_FIT_BIT      = 1;
  localparam int IRQ_WD_BIT       = 2;
  localparam int IRQ_W            = 3;

  // ----------------------------------------
  // time-base tap positions per select code
  // ----------------------------------------
  localparam logic [TAP_N-1:0][5:0] FIT_TAPS = {6'h15, 6'h11, 6'h0d, 6'h09};
  localparam logic [TAP_N-1:0][5:0] WD_TAPS  = {6'h19, 6'h15, 6'h11, 6'h0d};

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [TB_W-1:0]   TB_RST     = 64'h0;
  localparam logic [ITV_W-1:0]  ITV_RST    = 32'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 9'h000;
  localparam logic [IRQ_W-1:0]  IRQ_RST    = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST  = 32'h0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       wd_en;
    logic [1:0] wd_type;
    logic [1:0] wd_sel;
    logic [1:0] fit_sel;
    logic       auto_reload;
    logic       ext_src;
  } ctrl_s;

  typedef struct packed {
    logic wdog;
    logic fixed;
    logic interval;
  } irq_s;

endpackage

// ===== design/tick_source.sv
// module: picks the time-base advance from the cpu clock or the external tick
`timescale 1ns/1ns
module tick_source
  import cpu_timers_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // selection and external tick
  input  wire logic ext_src_i,
  input  wire logic ext_tick_i,
  // advance strobe
  output logic      advance_o
);

  logic ext_prev_reg;

  // ----------------------------------------
  // external tick edge
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_tick_i;
    end
  end

  // one advance per cpu clock, or per rising external edge
  assign advance_o = ext_src_i ? (ext_tick_i & ~ext_prev_reg) : 1'b1; // R2

endmodule

// ===== design/tap_rise.sv
// module: selects one of four time-base taps and flags its rising edge
`timescale 1ns/1ns
module tap_rise
  import cpu_timers_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // taps and select
  input  wire logic [TAP_N-1:0] taps_i,
  input  wire logic [1:0]       sel_i,
  // rising edge pulse
  output logic                  rise_o
);

  logic tap_prev_reg;
  logic tap_now;

  assign tap_now = taps_i[sel_i];

  // ----------------------------------------
  // previous tap value
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tap_prev_reg <= 1'b0;
    end else begin
      tap_prev_reg <= tap_now;
    end
  end

  // only the 0 to 1 change counts
  assign rise_o = tap_now & ~tap_prev_reg; // R10

endmodule

// ===== dv/core_exc_model.sv
// partner: core exception and reset logic watching the timer outputs
`timescale 1ns/1ns
module core_exc_model (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // from the timers
  input  wire logic       irq_i,
  input  wire logic       wd_reset_i,
  input  wire logic [1:0] wd_reset_type_i,
  // observations
  output logic [7:0]      resets_o,
  output logic [1:0]      type_o,
  output logic            long_o,
  output logic            irq_seen_o
);
  logic wd_reset_reg;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      wd_reset_reg <= 1'b0;
      resets_o     <= 8'h00;
      type_o       <= 2'h0;
      long_o       <= 1'b0;
      irq_seen_o   <= 1'b0;
    end else begin
      wd_reset_reg <= wd_reset_i;
      if (wd_reset_i) begin
        resets_o <= resets_o + 8'h01;
        type_o   <= wd_reset_type_i;
      end
      if (wd_reset_i && wd_reset_reg) begin
        long_o <= 1'b1;
      end
      if (irq_i) begin
        irq_seen_o <= 1'b1;
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
// testbench: time base and timers through the register port
`timescale 1ns/1ns
module tb_top;
  import cpu_timers_pkg::*;

  logic              ref_clk_i;
  logic              reset_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic              ext_tick_i = 1'b0;
  logic              irq_o;
  logic              wd_reset_o;
  logic [1:0]        wd_reset_type_o;
  logic [7:0]        resets;
  logic [1:0]        rst_type;
  logic              long_pulse;
  logic              irq_seen;
  logic [7:0]        cyc = 8'h00;
  int                num_errors;
  int                compares;

  cpu_timers i_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_tick_i(ext_tick_i),
    .irq_o(irq_o), .wd_reset_o(wd_reset_o), .wd_reset_type_o(wd_reset_type_o)
  );

  core_exc_model i_core (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .irq_i(irq_o), .wd_reset_i(wd_reset_o),
    .wd_reset_type_i(wd_reset_type_o), .resets_o(resets), .type_o(rst_type),
    .long_o(long_pulse), .irq_seen_o(irq_seen)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // external tick: one rise every four clocks
  always @(posedge ref_clk_i) begin
    cyc        <= cyc + 8'h01;
    ext_tick_i <= cyc[1];
  end

  task conclude();
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task wait_irq(input int lim);
    int i;
    i = 0;
    // skip the edge of the last write, so a level about to drop is not taken
    @(posedge ref_clk_i);
    #1;
    while (irq_o !== 1'b1 && i < lim) begin
      @(posedge ref_clk_i);
      #1;
      i++;
    end
    if (irq_o !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask

  task t_reset();
    logic [31:0] v;
    rd(OFS_CTRL, v);
    chk("ctrl", 32'h0, v);
    rd(OFS_MASK, v);
    chk("mask", 32'h0, v);
    rd(8'h1c, v);
    chk("unmapped", 32'h0, v);
    @(posedge ref_clk_i);
    #1;
    chk("rdata idle", 32'h0, rdata_o);
    chk("irq", 32'h0, irq_o);
  endtask

  task t_tbase();
    logic [31:0] a;
    logic [31:0] b;
    rd(OFS_TB_LO, a);
    repeat (5) @(posedge ref_clk_i);
    rd(OFS_TB_LO, b);
    chk("tb step", 32'h7, b - a);
    rd(OFS_TB_HI, b);
    chk("tb hi", 32'h0, b);
  endtask

  task t_interval();
    logic [31:0] a;
    logic [31:0] b;
    wr(OFS_ITV, 32'h14);
    repeat (30) @(posedge ref_clk_i);
    rd(OFS_ITV, a);
    chk("itv stop", 32'h0, a);
    rd(OFS_STATUS, a);
    chk("itv stat", 32'h1, a & 32'h1);
    chk("irq masked", 32'h0, irq_o);
    wr(OFS_MASK, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq itv", 32'h1, irq_o);
    wr(OFS_STATUS, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("irq clr", 32'h0, irq_o);
    wr(OFS_ITV, 32'h3e8);
    rd(OFS_ITV, a);
    repeat (8) @(posedge ref_clk_i);
    rd(OFS_ITV, b);
    chk("itv step", 32'ha, a - b);
  endtask

  task t_reload();
    logic [31:0] v;
    wr(OFS_CTRL, 32'h2);
    wr(OFS_ITV, 32'h8);
    repeat (30) @(posedge ref_clk_i);
    rd(OFS_ITV, v);
    chk("reload", 32'h1, v != 32'h0 && v <= 32'h8);
    rd(OFS_STATUS, v);
    chk("reload stat", 32'h1, v & 32'h1);
  endtask

  task t_ext();
    logic [31:0] a;
    logic [31:0] b;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_ITV, 32'h3e8);
    rd(OFS_TB_LO, a);
    repeat (38) @(posedge ref_clk_i);
    rd(OFS_TB_LO, b);
    chk("ext tb", 32'ha, b - a);
    rd(OFS_ITV, a);
    repeat (38) @(posedge ref_clk_i);
    rd(OFS_ITV, b);
    chk("ext itv", 32'ha, a - b);
    wr(OFS_CTRL, 32'h0);
  endtask

  task t_fixed();
    logic [31:0] v;
    wr(OFS_MASK, 32'h2);
    wr(OFS_STATUS, 32'h7);
    wait_irq(1200);
    rd(OFS_TB_LO, v);
    chk("fit tap", 32'h1, v[9:0] >= 10'h200 && v[9:0] < 10'h220);
    wr(OFS_STATUS, 32'h2);
    repeat (600) @(posedge ref_clk_i);
    rd(OFS_STATUS, v);
    chk("fit fall", 32'h0, v & 32'h2);
  endtask

  task t_fields();
    logic [31:0] v;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTRL, (c << 2) | (c << 4) | (c << 6));
      rd(OFS_CTRL, v);
      chk("ctrl sel", (c << 2) | (c << 4) | (c << 6), v);
    end
  endtask

  task t_wdog();
    logic [31:0] v;
    wr(OFS_CTRL, 32'h180);
    wr(OFS_MASK, 32'h4);
    wr(OFS_STATUS, 32'h7);
    wait_irq(17000);
    rd(OFS_STATUS, v);
    chk("wd irq stat", 32'h4, v & 32'h4);
    chk("wd irq", 32'h1, irq_seen);
    chk("no rst 1", 32'h0, resets);
    wr(OFS_STATUS, 32'h4);
    wr(OFS_CTRL, 32'h190);
    wr(OFS_CTRL, 32'h180);
    repeat (4) @(posedge ref_clk_i);
    rd(OFS_STATUS, v);
    chk("wd stat", 32'h4, v & 32'h4);
    chk("no rst 2", 32'h0, resets);
    wr(OFS_CTRL, 32'h190);
    wr(OFS_CTRL, 32'h180);
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("wd rst", 32'h1, resets);
    chk("wd type", 32'h2, rst_type);
    chk("rst pulse", 32'h0, long_pulse);
  endtask

  initial begin
    reset_i    = 1'b1;
    addr_i     = '0;
    wdata_i    = '0;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    num_errors = 0;
    compares   = 0;
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_tbase();
    t_interval();
    t_reload();
    t_ext();
    t_fixed();
    t_fields();
    t_wdog();
    conclude();
  end
endmodule
